// ### dci_defs.vh
// Behaviour
// - revision command returns major revision byte then minor revision byte
// - status command returns the whole eight-bit debug status register
// - 16-bit cycle counter from zero, saturates, read high byte first
// - counter is overwritten by memory and register access commands
// - control-write command loads the following byte into the control register
// - under read protect the debug mode bit can be set, never cleared
// - control-read command returns the current control register value
// - program counter write takes high then low byte, only when permitted
// - program counter read returns high then low byte, all ones if barred
// - register transfers move 1 to 256 bytes, size zero meaning 256
// - register writes dropped outside debug mode; protect allows flash control only
// - register read returns all-ones bytes when barred
// - program memory framing: 16-bit address, 16-bit size, zero means 65536
// - program memory writes need unlock, debug mode and no read protect
// - program memory read moves 1 to 65536 bytes, all ones when barred
`ifndef DCI_DEFS_VH
`define DCI_DEFS_VH

`define DCI_CMD_REV       8'h00
`define DCI_CMD_STAT      8'h02
`define DCI_CMD_RTC       8'h03
`define DCI_CMD_CTL_WR    8'h04
`define DCI_CMD_CTL_RD    8'h05
`define DCI_CMD_PC_WR     8'h06
`define DCI_CMD_PC_RD     8'h07
`define DCI_CMD_REG_WR    8'h08
`define DCI_CMD_REG_RD    8'h09
`define DCI_CMD_PMEM_WR   8'h0A
`define DCI_CMD_PMEM_RD   8'h0B

`define DCI_CTL_MODE_BIT  7
`define DCI_CTL_RESET     8'h00
`define DCI_STAT_RESET    7'h00
`define DCI_OPT_RESET     2'h0
`define DCI_OPT_PROTECT   0
`define DCI_OPT_UNLOCK    1
`define DCI_RTC_MAX       16'hFFFF
`define DCI_FILL_BYTE     8'hFF
`define DCI_REG_MAX       17'h00100
`define DCI_PMEM_MAX      17'h10000
`define DCI_FLASH_CTL_LO  12'hFF8
`define DCI_FLASH_CTL_HI  12'hFF9

`define DCI_OFF_OPTION    8'h00
`define DCI_OFF_CONTROL   8'h04
`define DCI_OFF_STATUS    8'h08
`define DCI_OFF_RUNTIME   8'h0C

`define DCI_RESP_OKAY     2'h0
`define DCI_RESP_SLVERR   2'h2

`endif

// ### dci_runtime_counter.v
`timescale 1ns/1ns
`include "dci_defs.vh"
module dci_runtime_counter
(
   input  wire        clock,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        run,
   input  wire        clear,
   output wire [15:0] count
);

reg [15:0] count_q;
reg        run_q;

assign count = count_q;

////////////////////////////////////////////////////////////////////////////////
// restarts each time the core leaves debug mode, holds while halted
always @(posedge clock or negedge rst_n)
begin
   if (!rst_n)
   begin
      count_q <= 16'h0000;
      run_q   <= 1'b0;
   end
   else if (ce)
   begin
      run_q <= run;
      if (clear || (run && !run_q))
         count_q <= 16'h0000;
      else if (run && count_q != `DCI_RTC_MAX)
         count_q <= count_q + 16'h0001;
   end
end

endmodule

// ### dci_axil_slave.v
`timescale 1ns/1ns
module dci_axil_slave
#(
   parameter ADDR_W = 8
)
(
   input  wire              clock,
   input  wire              rst_n,
   input  wire              ce,
   input  wire [ADDR_W-1:0] s_axil_awaddr,
   input  wire              s_axil_awvalid,
   output wire              s_axil_awready,
   input  wire [31:0]       s_axil_wdata,
   input  wire [3:0]        s_axil_wstrb,
   input  wire              s_axil_wvalid,
   output wire              s_axil_wready,
   output wire [1:0]        s_axil_bresp,
   output wire              s_axil_bvalid,
   input  wire              s_axil_bready,
   input  wire [ADDR_W-1:0] s_axil_araddr,
   input  wire              s_axil_arvalid,
   output wire              s_axil_arready,
   output wire [31:0]       s_axil_rdata,
   output wire [1:0]        s_axil_rresp,
   output wire              s_axil_rvalid,
   input  wire              s_axil_rready,
   output wire              wr_en,
   output wire [ADDR_W-1:0] wr_addr,
   output wire [31:0]       wr_data,
   output wire [3:0]        wr_strb,
   input  wire              wr_hit,
   output wire [ADDR_W-1:0] rd_addr,
   input  wire [31:0]       rd_data,
   input  wire              rd_hit
);

`include "dci_defs.vh"

reg              awready_q;
reg              wready_q;
reg              aw_full_q;
reg              w_full_q;
reg [ADDR_W-1:0] aw_q;
reg [31:0]       w_q;
reg [3:0]        ws_q;
reg              bvalid_q;
reg [1:0]        bresp_q;
reg              arready_q;
reg              rvalid_q;
reg [31:0]       rdata_q;
reg [1:0]        rresp_q;

assign s_axil_awready = awready_q;
assign s_axil_wready  = wready_q;
assign s_axil_bvalid  = bvalid_q;
assign s_axil_bresp   = bresp_q;
assign s_axil_arready = arready_q;
assign s_axil_rvalid  = rvalid_q;
assign s_axil_rdata   = rdata_q;
assign s_axil_rresp   = rresp_q;
// write fires once both halves are held, whichever came first
assign wr_en   = ce & aw_full_q & w_full_q & ~bvalid_q;
assign wr_addr = aw_q;
assign wr_data = w_q;
assign wr_strb = ws_q;
assign rd_addr = s_axil_araddr;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clock or negedge rst_n)
begin
   if (!rst_n)
   begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_q      <= {ADDR_W{1'b0}};
      w_q       <= 32'h00000000;
      ws_q      <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DCI_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `DCI_RESP_OKAY;
   end
   else if (ce)
   begin
      if (s_axil_awvalid && awready_q)
      begin
         aw_q      <= s_axil_awaddr;
         aw_full_q <= 1'b1;
         awready_q <= 1'b0;
      end
      if (s_axil_wvalid && wready_q)
      begin
         w_q      <= s_axil_wdata;
         ws_q     <= s_axil_wstrb;
         w_full_q <= 1'b1;
         wready_q <= 1'b0;
      end
      if (wr_en)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? `DCI_RESP_OKAY : `DCI_RESP_SLVERR;
      end
      else if (bvalid_q && s_axil_bready)
      begin
         bvalid_q  <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end
      if (s_axil_arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_hit ? rd_data : 32'h00000000;
         rresp_q   <= rd_hit ? `DCI_RESP_OKAY : `DCI_RESP_SLVERR;
      end
      else if (rvalid_q && s_axil_rready)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end
end

endmodule

// ### dci_debug_cmd.v
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "dci_defs.vh"
module dci_debug_cmd
#(
   parameter [15:0] REVISION = 16'h0101,  // arbitrary value
   parameter        ADDR_W   = 8
)
(
   input  wire              clock,
   input  wire              rst_n,
   input  wire              ce,
   input  wire [7:0]        rx_data,
   input  wire              rx_valid,
   output wire              rx_ready,
   output wire [7:0]        tx_data,
   output wire              tx_valid,
   input  wire              tx_ready,
   output wire [7:0]        debug_ctrl,
   output wire              debug_mode,
   input  wire [15:0]       cpu_pc,
   output wire              pc_load,
   output wire [15:0]       pc_value,
   output wire              mem_req,
   output wire              mem_we,
   output wire              mem_space,
   output wire [15:0]       mem_addr,
   output wire [7:0]        mem_wdata,
   input  wire [7:0]        mem_rdata,
   input  wire              mem_rvalid,
   input  wire [ADDR_W-1:0] s_axil_awaddr,
   input  wire              s_axil_awvalid,
   output wire              s_axil_awready,
   input  wire [31:0]       s_axil_wdata,
   input  wire [3:0]        s_axil_wstrb,
   input  wire              s_axil_wvalid,
   output wire              s_axil_wready,
   output wire [1:0]        s_axil_bresp,
   output wire              s_axil_bvalid,
   input  wire              s_axil_bready,
   input  wire [ADDR_W-1:0] s_axil_araddr,
   input  wire              s_axil_arvalid,
   output wire              s_axil_arready,
   output wire [31:0]       s_axil_rdata,
   output wire [1:0]        s_axil_rresp,
   output wire              s_axil_rvalid,
   input  wire              s_axil_rready
);

// bit 2 of the state code is the "accepting link bytes" flag
localparam [2:0] S_SEND  = 3'b000;
localparam [2:0] S_RREQ  = 3'b001;
localparam [2:0] S_RWAIT = 3'b010;
localparam [2:0] S_IDLE  = 3'b100;
localparam [2:0] S_ARG   = 3'b101;
localparam [2:0] S_WDATA = 3'b110;

reg [2:0]   state_q;
reg [7:0]   cmd_q;
reg [2:0]   argn_q;
reg [23:0]  arg_q;
reg [15:0]  resp_q;
reg         respn_q;
reg [16:0]  len_q;
reg [15:0]  addr_q;
reg [7:0]   ctrl_q;
reg [6:0]   stat_q;
reg [1:0]   opt_q;
reg [7:0]   tx_data_q;
reg         tx_valid_q;
reg         pc_load_q;
reg [15:0]  pc_value_q;
reg         mem_req_q;
reg         mem_we_q;
reg         mem_space_q;
reg [15:0]  mem_addr_q;
reg [7:0]   mem_wdata_q;
reg         rt_clear_q;

wire             rx_take;
wire             tx_done;
wire [31:0]      arg_full;
wire             dbg_ok;
wire             wr_ok;
wire [15:0]      rt_count;
wire             wr_en;
wire [ADDR_W-1:0] wr_addr;
wire [31:0]      wr_data;
wire [3:0]       wr_strb;
wire [ADDR_W-1:0] rd_addr;
reg  [31:0]      rd_data;
reg              rd_hit;
reg              wr_hit;

////////////////////////////////////////////////////////////////////////////////
function [2:0] arg_count;
   input [7:0] c;
   begin
      if (c == `DCI_CMD_CTL_WR)
         arg_count = 3'd1;
      else if (c == `DCI_CMD_PC_WR)
         arg_count = 3'd2;
      else if (c == `DCI_CMD_REG_WR || c == `DCI_CMD_REG_RD)
         arg_count = 3'd3;
      else if (c == `DCI_CMD_PMEM_WR || c == `DCI_CMD_PMEM_RD)
         arg_count = 3'd4;
      else
         arg_count = 3'd0;
   end
endfunction

function is_flash_ctl;
   input [11:0] a;
   begin
      is_flash_ctl = (a >= `DCI_FLASH_CTL_LO) && (a <= `DCI_FLASH_CTL_HI);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
assign rx_ready   = state_q[2];
assign rx_take    = ce & rx_valid & state_q[2];
assign tx_done    = tx_valid_q & tx_ready;
assign arg_full   = {arg_q, rx_data};
assign dbg_ok     = ctrl_q[`DCI_CTL_MODE_BIT] & ~opt_q[`DCI_OPT_PROTECT];
assign wr_ok      = (cmd_q == `DCI_CMD_REG_WR) ?
                    (ctrl_q[`DCI_CTL_MODE_BIT] &
                     (~opt_q[`DCI_OPT_PROTECT] | is_flash_ctl(addr_q[11:0]))) :
                    (dbg_ok & opt_q[`DCI_OPT_UNLOCK]);
assign tx_data    = tx_data_q;
assign tx_valid   = tx_valid_q;
assign debug_ctrl = ctrl_q;
assign debug_mode = ctrl_q[`DCI_CTL_MODE_BIT];
assign pc_load    = pc_load_q;
assign pc_value   = pc_value_q;
assign mem_req    = mem_req_q;
assign mem_we     = mem_we_q;
assign mem_space  = mem_space_q;
assign mem_addr   = mem_addr_q;
assign mem_wdata  = mem_wdata_q;

////////////////////////////////////////////////////////////////////////////////
dci_runtime_counter u_rtc
(
   .clock (clock),
   .rst_n (rst_n),
   .ce    (ce),
   .run   (~ctrl_q[`DCI_CTL_MODE_BIT]),
   .clear (rt_clear_q),
   .count (rt_count)
);

dci_axil_slave #(.ADDR_W(ADDR_W)) u_bus
(
   .clock          (clock),
   .rst_n          (rst_n),
   .ce             (ce),
   .s_axil_awaddr  (s_axil_awaddr),
   .s_axil_awvalid (s_axil_awvalid),
   .s_axil_awready (s_axil_awready),
   .s_axil_wdata   (s_axil_wdata),
   .s_axil_wstrb   (s_axil_wstrb),
   .s_axil_wvalid  (s_axil_wvalid),
   .s_axil_wready  (s_axil_wready),
   .s_axil_bresp   (s_axil_bresp),
   .s_axil_bvalid  (s_axil_bvalid),
   .s_axil_bready  (s_axil_bready),
   .s_axil_araddr  (s_axil_araddr),
   .s_axil_arvalid (s_axil_arvalid),
   .s_axil_arready (s_axil_arready),
   .s_axil_rdata   (s_axil_rdata),
   .s_axil_rresp   (s_axil_rresp),
   .s_axil_rvalid  (s_axil_rvalid),
   .s_axil_rready  (s_axil_rready),
   .wr_en          (wr_en),
   .wr_addr        (wr_addr),
   .wr_data        (wr_data),
   .wr_strb        (wr_strb),
   .wr_hit         (wr_hit),
   .rd_addr        (rd_addr),
   .rd_data        (rd_data),
   .rd_hit         (rd_hit)
);

////////////////////////////////////////////////////////////////////////////////
// software side map
always @*
begin
   rd_data = 32'h00000000;
   rd_hit  = 1'b1;
   if (rd_addr == `DCI_OFF_OPTION)
      rd_data = {30'h00000000, opt_q};
   else if (rd_addr == `DCI_OFF_CONTROL)
      rd_data = {24'h000000, ctrl_q};
   else if (rd_addr == `DCI_OFF_STATUS)
      rd_data = {24'h000000, ctrl_q[`DCI_CTL_MODE_BIT], stat_q};
   else if (rd_addr == `DCI_OFF_RUNTIME)
      rd_data = {16'h0000, rt_count};
   else
      rd_hit = 1'b0;
end

always @*
begin
   wr_hit = (wr_addr == `DCI_OFF_OPTION) || (wr_addr == `DCI_OFF_CONTROL) ||
            (wr_addr == `DCI_OFF_STATUS) || (wr_addr == `DCI_OFF_RUNTIME);
end

always @(posedge clock or negedge rst_n)
begin
   if (!rst_n)
   begin
      opt_q  <= `DCI_OPT_RESET;
      stat_q <= `DCI_STAT_RESET;
   end
   else if (wr_en && wr_strb[0])
   begin
      // control and runtime words ignore writes
      if (wr_addr == `DCI_OFF_OPTION)
         opt_q <= wr_data[1:0];
      else if (wr_addr == `DCI_OFF_STATUS)
         stat_q <= wr_data[6:0];
   end
end

////////////////////////////////////////////////////////////////////////////////
// command sequencer
always @(posedge clock or negedge rst_n)
begin
   if (!rst_n)
   begin
      state_q     <= S_IDLE;
      cmd_q       <= 8'h00;
      argn_q      <= 3'd0;
      arg_q       <= 24'h000000;
      resp_q      <= 16'h0000;
      respn_q     <= 1'b0;
      len_q       <= 17'h00000;
      addr_q      <= 16'h0000;
      ctrl_q      <= `DCI_CTL_RESET;
      tx_data_q   <= 8'h00;
      tx_valid_q  <= 1'b0;
      pc_load_q   <= 1'b0;
      pc_value_q  <= 16'h0000;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_space_q <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
      rt_clear_q  <= 1'b0;
   end
   else if (ce)
   begin
      pc_load_q  <= 1'b0;
      mem_req_q  <= 1'b0;
      rt_clear_q <= 1'b0;
      case (state_q)
      S_IDLE:
         if (rx_take)
         begin
            cmd_q  <= rx_data;
            argn_q <= arg_count(rx_data);
            if (rx_data == `DCI_CMD_REV)
            begin
               tx_data_q  <= REVISION[15:8];
               resp_q     <= {REVISION[7:0], 8'h00};
               respn_q    <= 1'b1;
               tx_valid_q <= 1'b1;
               state_q    <= S_SEND;
            end
            else if (rx_data == `DCI_CMD_STAT)
            begin
               tx_data_q  <= {ctrl_q[`DCI_CTL_MODE_BIT], stat_q};
               respn_q    <= 1'b0;
               tx_valid_q <= 1'b1;
               state_q    <= S_SEND;
            end
            else if (rx_data == `DCI_CMD_RTC)
            begin
               tx_data_q  <= rt_count[15:8];
               resp_q     <= {rt_count[7:0], 8'h00};
               respn_q    <= 1'b1;
               tx_valid_q <= 1'b1;
               state_q    <= S_SEND;
            end
            else if (rx_data == `DCI_CMD_CTL_RD)
            begin
               tx_data_q  <= ctrl_q;
               respn_q    <= 1'b0;
               tx_valid_q <= 1'b1;
               state_q    <= S_SEND;
            end
            else if (rx_data == `DCI_CMD_PC_RD)
            begin
               tx_data_q  <= dbg_ok ? cpu_pc[15:8] : `DCI_FILL_BYTE;
               resp_q     <= {(dbg_ok ? cpu_pc[7:0] : `DCI_FILL_BYTE), 8'h00};
               respn_q    <= 1'b1;
               tx_valid_q <= 1'b1;
               state_q    <= S_SEND;
            end
            else if (arg_count(rx_data) != 3'd0)
               state_q <= S_ARG;
            // any other byte just falls through
         end
      S_ARG:
         if (rx_take)
         begin
            arg_q  <= arg_full[23:0];
            argn_q <= argn_q - 3'd1;
            if (argn_q == 3'd1)
            begin
               state_q <= S_IDLE;
               if (cmd_q == `DCI_CMD_CTL_WR)
               begin
                  ctrl_q <= rx_data;
                  // protected part: once in debug mode only reset or clearing the protect option bit gets out
                  if (opt_q[`DCI_OPT_PROTECT] && ctrl_q[`DCI_CTL_MODE_BIT])
                     ctrl_q[`DCI_CTL_MODE_BIT] <= 1'b1;
               end
               else if (cmd_q == `DCI_CMD_PC_WR)
               begin
                  if (dbg_ok)
                  begin
                     pc_load_q  <= 1'b1;
                     pc_value_q <= arg_full[15:0];
                  end
               end
               else if (cmd_q == `DCI_CMD_REG_WR || cmd_q == `DCI_CMD_REG_RD)
               begin
                  addr_q     <= {4'h0, arg_full[19:8]};
                  len_q      <= (arg_full[7:0] == 8'h00) ? `DCI_REG_MAX :
                                {9'h000, arg_full[7:0]};
                  rt_clear_q <= 1'b1;
                  state_q    <= (cmd_q == `DCI_CMD_REG_WR) ? S_WDATA : S_RREQ;
               end
               else
               begin
                  addr_q     <= arg_full[31:16];
                  len_q      <= (arg_full[15:0] == 16'h0000) ? `DCI_PMEM_MAX :
                                {1'b0, arg_full[15:0]};
                  rt_clear_q <= 1'b1;
                  state_q    <= (cmd_q == `DCI_CMD_PMEM_WR) ? S_WDATA : S_RREQ;
               end
            end
         end
      S_WDATA:
         if (rx_take)
         begin
            // barred bytes are still consumed so framing stays intact
            if (wr_ok)
            begin
               mem_req_q   <= 1'b1;
               mem_we_q    <= 1'b1;
               mem_space_q <= (cmd_q == `DCI_CMD_PMEM_WR);
               mem_addr_q  <= addr_q;
               mem_wdata_q <= rx_data;
            end
            addr_q <= addr_q + 16'h0001;
            len_q  <= len_q - 17'h00001;
            if (len_q == 17'h00001)
               state_q <= S_IDLE;
         end
      S_RREQ:
         if (dbg_ok)
         begin
            mem_req_q   <= 1'b1;
            mem_we_q    <= 1'b0;
            mem_space_q <= (cmd_q == `DCI_CMD_PMEM_RD);
            mem_addr_q  <= addr_q;
            state_q     <= S_RWAIT;
         end
         else
         begin
            tx_data_q  <= `DCI_FILL_BYTE;
            tx_valid_q <= 1'b1;
            respn_q    <= 1'b0;
            addr_q     <= addr_q + 16'h0001;
            len_q      <= len_q - 17'h00001;
            state_q    <= S_SEND;
         end
      S_RWAIT:
         if (mem_rvalid)
         begin
            tx_data_q  <= mem_rdata;
            tx_valid_q <= 1'b1;
            respn_q    <= 1'b0;
            addr_q     <= addr_q + 16'h0001;
            len_q      <= len_q - 17'h00001;
            state_q    <= S_SEND;
         end
      S_SEND:
         if (tx_done)
         begin
            if (respn_q)
            begin
               tx_data_q <= resp_q[15:8];
               respn_q   <= 1'b0;
            end
            else
            begin
               tx_valid_q <= 1'b0;
               if ((cmd_q == `DCI_CMD_REG_RD || cmd_q == `DCI_CMD_PMEM_RD) &&
                   len_q != 17'h00000)
                  state_q <= S_RREQ;
               else
                  state_q <= S_IDLE;
            end
         end
      default:
         state_q <= S_IDLE;
      endcase
   end
end

endmodule

// ### dci_host_model.sv
`timescale 1ns/1ns
module dci_host_model
(
   input  wire        clock,
   input  wire        rx_ready,
   input  wire  [7:0] tx_data,
   input  wire        tx_valid,
   output logic [7:0] rx_data,
   output logic       rx_valid,
   output logic       tx_ready
);
   integer lost = 0;
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   task send(input logic [7:0] b);
      integer n;
      rx_data <= b;
      rx_valid <= 1'b1;
      n = 0;
      @(posedge clock);
      while (!rx_ready && n < 99)
      begin
         @(posedge clock);
         n = n + 1;
      end
      if (n == 99)
         lost = lost + 1;
   endtask
   // released line shows the inverse
   task idle;
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      @(posedge clock);
   endtask
   // slow reader: two stalls per byte
   task recv(output logic [7:0] b);
      integer n;
      repeat (2) @(posedge clock);
      tx_ready <= 1'b1;
      n = 0;
      @(posedge clock);
      while (!tx_valid && n < 99)
      begin
         @(posedge clock);
         n = n + 1;
      end
      b = tx_data;
      tx_ready <= 1'b0;
      if (n == 99)
         lost = lost + 1;
   endtask
endmodule

// ### dci_checker_properties.sv
`timescale 1ns/1ns
module dci_checker
(
   input wire        clock,
   input wire        rst_n,
   input wire        tx_valid,
   input wire        tx_ready,
   input wire [7:0]  tx_data,
   input wire        rx_ready,
   input wire [7:0]  debug_ctrl,
   input wire        debug_mode,
   input wire        pc_load,
   input wire        mem_req,
   input wire        mem_we,
   input wire        mem_space,
   input wire [15:0] mem_addr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte dropped early");
   chk_rx_shut: assert property (tx_valid |-> !rx_ready)
      else $error("rx open while sending");
   chk_mode_bit: assert property (debug_mode == debug_ctrl[7])
      else $error("mode bit differs");
   chk_pc_gate: assert property (pc_load |-> debug_mode ##1 !pc_load)
      else $error("pc load bad");
   chk_reg_write: assert property (mem_req && mem_we |-> debug_mode)
      else $error("write outside debug");
   chk_addr_pad: assert property (mem_req && !mem_space |-> mem_addr[15:12] == 4'h0)
      else $error("reg address high nibble");
   chk_pmem_gate: assert property (mem_req && mem_we && mem_space |-> debug_mode)
      else $error("pmem write outside debug");
   chk_req_quiet: assert property (mem_req |-> !tx_valid)
      else $error("request while sending");
   cover property (pc_load);
   cover property (mem_req && mem_we && mem_space);
   cover property (tx_valid && !tx_ready);
endmodule
bind dci_debug_cmd dci_checker u_chk
(
   .clock(clock), .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_data(tx_data), .rx_ready(rx_ready), .debug_ctrl(debug_ctrl), .debug_mode(debug_mode),
   .pc_load(pc_load), .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space),
   .mem_addr(mem_addr)
);

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] cpu_pc = 16'h0000;
   logic [7:0]  mem_rdata = 8'h00;
   logic        mem_rvalid = 1'b0;
   logic [7:0]  s_axil_awaddr = 8'h00;
   logic [7:0]  s_axil_araddr = 8'h00;
   logic [31:0] s_axil_wdata = 32'h00000000;
   logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
   logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
   wire  [31:0] s_axil_rdata;
   wire  [15:0] mem_addr, pc_value;
   wire  [7:0]  rx_data, tx_data, mem_wdata, debug_ctrl;
   wire  [1:0]  s_axil_bresp, s_axil_rresp;
   wire         rx_valid, rx_ready, tx_valid, tx_ready, debug_mode, pc_load, mem_req;
   wire         mem_we, mem_space, s_axil_awready, s_axil_wready, s_axil_bvalid;
   wire         s_axil_arready, s_axil_rvalid;
   logic [7:0]  exp_q[$];
   logic [15:0] pcv = 16'h0000, wa, wd, wn = 16'h0000;
   logic [31:0] seed;
   integer      fail_count = 0, checked = 0, i;
   always #4 clock = ~clock;
   dci_debug_cmd u_dci_debug_cmd
   (
      .clock(clock), .rst_n(rst_n), .ce(1'b1), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .debug_ctrl(debug_ctrl), .debug_mode(debug_mode), .cpu_pc(cpu_pc), .pc_load(pc_load),
      .pc_value(pc_value), .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_rvalid(mem_rvalid), .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(4'hF),
      .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready)
   );
   dci_host_model u_host
   (
      .clock(clock), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready)
   );
   // memory model: reads answer next cycle
   always @(posedge clock)
   begin
      mem_rvalid <= mem_req & ~mem_we;
      mem_rdata <= mem_addr[7:0] ^ 8'hA5;
      if (pc_load)
         pcv <= pc_value;
      if (mem_req & mem_we)
      begin
         wn <= wn + 16'h0001;
         wa <= mem_addr;
         wd <= {7'h00, mem_space, mem_wdata};
      end
   end
   ////////////////////////////////////////////////////////////
   task check(input logic [15:0] seen, want);
      checked = checked + 1;
      if (seen !== want)
      begin
         fail_count = fail_count + 1;
         $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task cmd(input logic [63:0] b, input integer k, n);
      logic [7:0] r;
      integer j;
      for (j = k - 1; j >= 0; j = j - 1)
         u_host.send(b[8*j +: 8]);
      u_host.idle();
      for (j = 0; j < n; j = j + 1)
      begin
         u_host.recv(r);
         check({8'h00, r}, {8'h00, exp_q.pop_front()});
      end
      repeat (2) @(posedge clock);
   endtask
   // one write (wr=1) or one read; e is the expected response code
   task ax(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      integer n;
      s_axil_awaddr <= a;
      s_axil_araddr <= a;
      s_axil_wdata <= d;
      s_axil_awvalid <= wr;
      s_axil_wvalid <= wr;
      s_axil_bready <= wr;
      s_axil_arvalid <= !wr;
      s_axil_rready <= !wr;
      n = 0;
      while (n < 99)
      begin
         @(posedge clock);
         n = n + 1;
         if (s_axil_awready)
            s_axil_awvalid <= 1'b0;
         if (s_axil_wready)
            s_axil_wvalid <= 1'b0;
         if (s_axil_arready)
            s_axil_arvalid <= 1'b0;
         if (wr ? s_axil_bvalid : s_axil_rvalid)
         begin
            check({wr ? s_axil_bresp : s_axil_rresp, wr ? d[13:0] : s_axil_rdata[13:0]},
                  {e, d[13:0]});
            n = 100;
         end
      end
      check(n[15:0], 16'h0064);
      s_axil_bready <= 1'b0;
      s_axil_rready <= 1'b0;
      @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      fail_count = fail_count + 1;
      give_verdict;
   end
   initial
   begin
      seed = 32'hCD0097D3;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      cpu_pc <= $random(seed);
      @(posedge clock);
      exp_q = '{8'h01, 8'h01, 8'h55};
      cmd(64'h0100, 2, 2);
      ax(1, 8'h08, 32'h000000D5, 2'h0);
      cmd(64'h02, 1, 1);
      cmd(64'h0480, 2, 0);
      exp_q = '{8'h80, cpu_pc[15:8], cpu_pc[7:0]};
      cmd(64'h05, 1, 1);
      cmd(64'h07, 1, 2);
      cmd(64'h061234, 3, 0);
      check(pcv, 16'h1234);
      for (i = 0; i < 256; i = i + 1)
         exp_q.push_back(i[7:0] ^ 8'hA5);
      cmd(64'h09000000, 4, 256);
      exp_q = '{8'h00, 8'h00};
      cmd(64'h03, 1, 2);
      cmd(64'h080010013C, 5, 0);
      check(wa ^ wd, 16'h002C);
      cmd(64'h0A002000017E, 6, 0);
      check(wn, 16'h0001);
      ax(1, 8'h00, 32'h00000002, 2'h0);
      cmd(64'h0A002000017E, 6, 0);
      check(wa ^ wd, 16'h015E);
      ax(1, 8'h00, 32'h00000001, 2'h0);
      cmd(64'h0400, 2, 0);
      exp_q = '{8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      cmd(64'h05, 1, 1);
      cmd(64'h07, 1, 2);
      cmd(64'h09000001, 4, 1);
      cmd(64'h0B00000001, 5, 1);
      ax(0, 8'h04, 32'h00000080, 2'h0);
      ax(0, 8'h10, 32'h00000000, 2'h2);
      check(u_host.lost, 16'h0000);
      give_verdict;
   end
endmodule
